// file: rtl/sfcd_decoder.sv
// Serial flash command front end: framing, opcode and address decode
// =====================================================================
// How it works
// RL1 - Host drops chip select before first clock, holds it low through.
// RL2 - A frame ending off a byte boundary is dropped without effect.
// RL3 - Host drives select, clock, input; device drives output or IO.
// RL4 - Address-length bit set makes legacy commands take four bytes.
// RL5 - Reset or soft reset reloads address length from default bit; a B7 or E9 frame end in the same cycle overrides the soft reset.
// RL6 - Wide read opcodes 13, 0C, BC always take a 32-bit address.
// RL7 - Wide erase opcodes 53, DC always take a 32-bit address.
// RL8 - Legacy 03, 0B, 02 grow to four address bytes in wide mode.
// RL9 - 05 returns status one, 07 status two, not in quad mode.
// RL10 - 35, 15, 33 return config one to three, no address.
// RL11 - 01 writes status one then config one through three.
// RL12 - 06 enables non-volatile writes, 50 volatile register writes.
// RL13 - B7 enters wide address mode, E9 leaves it.
// RL14 - 41 reads pattern, 43 and 4A write learning registers.
// RL15 - 5A streams parameter data after a mode-sized address.
// RL16 - 9F, AF, 4B return identification with no address.
// RL17 - Lock read, lock, unlock and pointer-region use mode address.
// RL18 - Host avoids commands unsupported in quad mode while active.
// RL19 - Unknown opcode: ignore rest of frame, keep output undriven.
// RL20 - Chip select high clears all bit counters.
`include "sfcd_map.svh"

module sfcd_decoder
  import sfcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cs_b_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] quad_io_lines_in,
  input wire logic addr_len_default_bit,
  input wire logic soft_reset,
  input wire logic quad_peripheral_mode,
  input wire logic write_enable_clear,
  input wire logic [7:0] rd_data,
  output logic [3:0] quad_io_lines_out,
  output logic [3:0] quad_io_lines_oe,
  output logic addr_len_volatile_bit,
  output logic nv_write_enable,
  output logic volatile_write_enable,
  output logic [7:0] cmd_opcode,
  output logic [31:0] cmd_addr,
  output logic cmd_wide,
  output sfcd_src_t rd_src,
  output logic cmd_start,
  output logic cmd_done,
  output logic cmd_discard,
  output logic rd_next,
  output logic wr_strobe,
  output logic [2:0] wr_index,
  output logic [7:0] wr_data
);
  // ===================================================================
  // Pin synchronisers
  logic [5:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic [3:0] io_s;

  sfcd_sync #(
    .W(6),
    // Select idles high, clock idles low: no false edge after reset
    .RST_VAL(6'h20)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .d({cs_b_pin, sclk_pin, quad_io_lines_in}),
    .q(pins_s)
  );

  assign cs_s = pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s = pins_s[3:0];

  // ===================================================================
  // Opcode table
  function automatic sfcd_cmd_t sfcd_decode(input logic [7:0] op);
    sfcd_cmd_t c;
    c = '0;
    case (op)
      `SFCD_OP_READ, `SFCD_OP_FREAD, `SFCD_OP_DOREAD, `SFCD_OP_QOREAD,
      `SFCD_OP_DIOREAD: // [RL8]
        c = sfcd_mk(1'b0, SFCD_AL_MODE, 1'b1, 1'b0, SFCD_SRC_ARRAY);
      `SFCD_OP_WREAD, `SFCD_OP_WFREAD, `SFCD_OP_WDOREAD,
      `SFCD_OP_WQOREAD, `SFCD_OP_WDIOREAD: // [RL6]
        c = sfcd_mk(1'b0, SFCD_AL_WIDE, 1'b1, 1'b0, SFCD_SRC_ARRAY);
      `SFCD_OP_QIOREAD, `SFCD_OP_DDRREAD:
        c = sfcd_mk(1'b1, SFCD_AL_MODE, 1'b1, 1'b0, SFCD_SRC_ARRAY);
      `SFCD_OP_WQIOREAD, `SFCD_OP_WDDRREAD:
        c = sfcd_mk(1'b1, SFCD_AL_WIDE, 1'b1, 1'b0, SFCD_SRC_ARRAY);
      `SFCD_OP_PROG, `SFCD_OP_PTR_SET: // [RL8] [RL17]
        c = sfcd_mk(1'b1, SFCD_AL_MODE, 1'b0, 1'b1, SFCD_SRC_NONE);
      `SFCD_OP_WPROG, `SFCD_OP_WPTR_SET:
        c = sfcd_mk(1'b1, SFCD_AL_WIDE, 1'b0, 1'b1, SFCD_SRC_NONE);
      `SFCD_OP_QPROG:
        c = sfcd_mk(1'b0, SFCD_AL_MODE, 1'b0, 1'b1, SFCD_SRC_NONE);
      `SFCD_OP_WQPROG:
        c = sfcd_mk(1'b0, SFCD_AL_WIDE, 1'b0, 1'b1, SFCD_SRC_NONE);
      `SFCD_OP_SECT_ER, `SFCD_OP_HALF_ER, `SFCD_OP_BLK_ER,
      `SFCD_OP_LOCK_SET, `SFCD_OP_LOCK_CLR: // [RL17]
        c = sfcd_mk(1'b1, SFCD_AL_MODE, 1'b0, 1'b0, SFCD_SRC_NONE);
      `SFCD_OP_WSECT_ER, `SFCD_OP_WHALF_ER, `SFCD_OP_WBLK_ER,
      `SFCD_OP_WLOCK_SET, `SFCD_OP_WLOCK_CLR: // [RL7]
        c = sfcd_mk(1'b1, SFCD_AL_WIDE, 1'b0, 1'b0, SFCD_SRC_NONE);
      `SFCD_OP_LOCK_RD: // [RL17]
        c = sfcd_mk(1'b1, SFCD_AL_MODE, 1'b1, 1'b0, SFCD_SRC_LOCK);
      `SFCD_OP_WLOCK_RD:
        c = sfcd_mk(1'b1, SFCD_AL_WIDE, 1'b1, 1'b0, SFCD_SRC_LOCK);
      `SFCD_OP_PARAM: // [RL15]
        c = sfcd_mk(1'b1, SFCD_AL_MODE, 1'b1, 1'b0, SFCD_SRC_PARAM);
      `SFCD_OP_MAKER_ID: // [RL16]
        c = sfcd_mk(1'b1, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_MAKER);
      `SFCD_OP_QUAD_ID: // [RL16]
        c = sfcd_mk(1'b1, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_QUAD_ID);
      `SFCD_OP_UNIQ_ID: // [RL16]
        c = sfcd_mk(1'b1, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_UNIQ_ID);
      `SFCD_OP_STAT1: // [RL9]
        c = sfcd_mk(1'b1, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_STAT1);
      `SFCD_OP_STAT2: // [RL9]
        c = sfcd_mk(1'b0, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_STAT2);
      `SFCD_OP_CFG1: // [RL10]
        c = sfcd_mk(1'b0, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_CFG1);
      `SFCD_OP_CFG2: // [RL10]
        c = sfcd_mk(1'b0, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_CFG2);
      `SFCD_OP_CFG3: // [RL10]
        c = sfcd_mk(1'b0, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_CFG3);
      `SFCD_OP_LRN_RD: // [RL14]
        c = sfcd_mk(1'b1, SFCD_AL_NONE, 1'b1, 1'b0, SFCD_SRC_LEARN);
      `SFCD_OP_REG_WR, `SFCD_OP_LRN_NV, `SFCD_OP_LRN_V: // [RL11] [RL14]
        c = sfcd_mk(1'b1, SFCD_AL_NONE, 1'b0, 1'b1, SFCD_SRC_NONE);
      `SFCD_OP_NV_WEN, `SFCD_OP_V_WEN, `SFCD_OP_WIDE_ON,
      `SFCD_OP_WIDE_OFF: // [RL12] [RL13]
        c = sfcd_mk(1'b1, SFCD_AL_NONE, 1'b0, 1'b0, SFCD_SRC_NONE);
      default:
        c = '0;
    endcase
    return c;
  endfunction

  // Phase that follows the opcode or the address
  function automatic sfcd_phase_t sfcd_body(input sfcd_cmd_t c);
    if (c.dout) begin
      return SFCD_DOUT;
    end else if (c.din) begin
      return SFCD_DIN;
    end else begin
      return SFCD_WAIT;
    end
  endfunction

  // ===================================================================
  // Next-state logic
  sfcd_state_t st_r;
  sfcd_state_t st_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic [2:0] step;
  logic [7:0] byte_nxt;
  logic [5:0] cnt_nxt;
  logic [5:0] addr_bits;
  logic [7:0] dsrc;
  sfcd_cmd_t dec;

  assign sclk_rise = sclk_s & ~st_r.sclk_d;
  assign sclk_fall = ~sclk_s & st_r.sclk_d;
  assign step = quad_peripheral_mode ? 3'h4 : 3'h1;
  assign byte_nxt = quad_peripheral_mode ? {st_r.in_sr[3:0], io_s}
                                         : {st_r.in_sr[6:0], io_s[0]};
  assign cnt_nxt = st_r.ph_cnt + {3'h0, step};
  assign addr_bits = st_r.wide ? `SFCD_ADDR4_BITS : `SFCD_ADDR3_BITS;
  assign dec = sfcd_decode(byte_nxt);
  assign dsrc = (st_r.out_cnt == 4'h0) ? rd_data : st_r.out_sr;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd_start = 1'b0;
    st_nxt.cmd_done = 1'b0;
    st_nxt.cmd_discard = 1'b0;
    st_nxt.rd_next = 1'b0;
    st_nxt.wr_strobe = 1'b0;
    st_nxt.sclk_d = sclk_s;
    // Strap is caught on the first clock after reset release
    if (!st_r.loaded || soft_reset) begin
      st_nxt.addr_len = addr_len_default_bit; // [RL5]
      st_nxt.loaded = 1'b1;
    end
    if (write_enable_clear) begin
      st_nxt.nv_wel = 1'b0;
      st_nxt.v_wel = 1'b0;
    end
    if (cs_s) begin
      // Frame end; commands act here so a torn frame has no effect
      if (st_r.tot_bits != 3'h0) begin
        st_nxt.cmd_discard = 1'b1; // [RL2]
      end else if (st_r.phase inside {SFCD_DOUT, SFCD_DIN, SFCD_WAIT})
      begin
        st_nxt.cmd_done = 1'b1;
        case (st_r.opc)
          `SFCD_OP_NV_WEN: st_nxt.nv_wel = 1'b1; // [RL12]
          `SFCD_OP_V_WEN: st_nxt.v_wel = 1'b1; // [RL12]
          `SFCD_OP_WIDE_ON: st_nxt.addr_len = 1'b1; // [RL13]
          `SFCD_OP_WIDE_OFF: st_nxt.addr_len = 1'b0; // [RL13]
          default: st_nxt.cmd_done = 1'b1;
        endcase
      end else if (st_r.phase == SFCD_ADDR) begin
        st_nxt.cmd_discard = 1'b1;
      end
      st_nxt.phase = SFCD_IDLE;
      st_nxt.tot_bits = 3'h0; // [RL20]
      st_nxt.ph_cnt = 6'h00; // [RL20]
      st_nxt.out_cnt = 4'h0;
      st_nxt.wr_idx = 3'h0;
      st_nxt.io_oe = 4'h0;
    end else begin
      if (st_r.phase == SFCD_IDLE) begin
        st_nxt.phase = SFCD_OPC; // [RL1]
      end
      if (sclk_rise && st_r.phase != SFCD_IDLE) begin
        st_nxt.tot_bits = st_r.tot_bits + step;
        st_nxt.ph_cnt = cnt_nxt;
        unique case (st_r.phase)
          SFCD_OPC: begin
            st_nxt.in_sr = byte_nxt;
            if (cnt_nxt == `SFCD_BYTE_BITS) begin
              st_nxt.opc = byte_nxt;
              st_nxt.cmd = dec;
              st_nxt.ph_cnt = 6'h00;
              st_nxt.addr = 32'h0000_0000;
              st_nxt.wide = (dec.alen == SFCD_AL_WIDE) ||
                            st_r.addr_len; // [RL4] [RL6] [RL7]
              // Quad-mode exclusions treated as unknown
              if (!dec.known ||
                  (quad_peripheral_mode && !dec.qpi_ok)) begin
                st_nxt.phase = SFCD_SKIP; // [RL19]
              end else if (dec.alen != SFCD_AL_NONE) begin
                st_nxt.phase = SFCD_ADDR;
              end else begin
                st_nxt.phase = sfcd_body(dec);
                st_nxt.cmd_start = 1'b1;
              end
            end
          end
          SFCD_ADDR: begin
            st_nxt.addr = quad_peripheral_mode
                          ? {st_r.addr[27:0], io_s}
                          : {st_r.addr[30:0], io_s[0]};
            if (cnt_nxt == addr_bits) begin // [RL4] [RL8]
              st_nxt.phase = sfcd_body(st_r.cmd);
              st_nxt.ph_cnt = 6'h00;
              st_nxt.cmd_start = 1'b1;
            end
          end
          SFCD_DIN: begin
            st_nxt.in_sr = byte_nxt;
            if (cnt_nxt == `SFCD_BYTE_BITS) begin
              st_nxt.ph_cnt = 6'h00;
              st_nxt.wr_strobe = 1'b1;
              st_nxt.wr_data = byte_nxt;
              st_nxt.wr_idx = st_r.wr_idx;
              if (st_r.wr_idx != 3'h7) begin
                st_nxt.wr_idx = st_r.wr_idx + 3'h1;
              end
              // Status one then config one to three, extras ignored
              if (st_r.opc == `SFCD_OP_REG_WR &&
                  st_r.wr_idx == `SFCD_REG_WR_LAST) begin
                st_nxt.phase = SFCD_WAIT; // [RL11]
              end
            end
          end
          SFCD_DOUT, SFCD_WAIT, SFCD_SKIP: begin
            st_nxt.ph_cnt = 6'h00;
          end
          default: begin
            st_nxt.ph_cnt = 6'h00;
          end
        endcase
      end
      // Output shifts on the falling edge, MSB first
      if (sclk_fall && st_r.phase == SFCD_DOUT) begin // [RL3]
        st_nxt.rd_next = (st_r.out_cnt == 4'h0);
        if (quad_peripheral_mode) begin
          st_nxt.io_out = dsrc[7:4];
          st_nxt.io_oe = 4'hf;
          st_nxt.out_sr = {dsrc[3:0], 4'h0};
          st_nxt.out_cnt = (st_r.out_cnt == 4'h0) ? 4'h4
                           : st_r.out_cnt - 4'h4;
        end else begin
          st_nxt.io_out = {2'h0, dsrc[7], 1'b0};
          st_nxt.io_oe = 4'h2;
          st_nxt.out_sr = {dsrc[6:0], 1'b0};
          st_nxt.out_cnt = (st_r.out_cnt == 4'h0) ? 4'h7
                           : st_r.out_cnt - 4'h1;
        end
      end
      if (st_r.phase != SFCD_DOUT) begin
        st_nxt.io_oe = 4'h0; // [RL19]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===================================================================
  // Outputs
  assign quad_io_lines_out = st_r.io_out;
  assign quad_io_lines_oe = st_r.io_oe;
  assign addr_len_volatile_bit = st_r.addr_len;
  assign nv_write_enable = st_r.nv_wel;
  assign volatile_write_enable = st_r.v_wel;
  assign cmd_opcode = st_r.opc;
  assign cmd_addr = st_r.addr;
  assign cmd_wide = st_r.wide;
  assign rd_src = st_r.cmd.src;
  assign cmd_start = st_r.cmd_start;
  assign cmd_done = st_r.cmd_done;
  assign cmd_discard = st_r.cmd_discard;
  assign rd_next = st_r.rd_next;
  assign wr_strobe = st_r.wr_strobe;
  assign wr_index = st_r.wr_idx;
  assign wr_data = st_r.wr_data;

  // ===================================================================
  // Checks
  property p_torn_frame;
    @(posedge core_clk) disable iff (!rst_b)
    cs_s && st_r.tot_bits != 3'h0 |=> cmd_discard && !cmd_done;
  endproperty
  a_torn_frame: assert property (p_torn_frame) // [RL2]
    else $error("torn frame not discarded");

  property p_wide_read;
    @(posedge core_clk) disable iff (!rst_b)
    cmd_start && cmd_opcode inside {`SFCD_OP_WREAD, `SFCD_OP_WFREAD,
      `SFCD_OP_WDIOREAD} |-> cmd_wide && rd_src == SFCD_SRC_ARRAY;
  endproperty
  a_wide_read: assert property (p_wide_read) // [RL6]
    else $error("wide read without 32-bit address");

  property p_wide_erase;
    @(posedge core_clk) disable iff (!rst_b)
    cmd_start && cmd_opcode inside {`SFCD_OP_WHALF_ER,
      `SFCD_OP_WBLK_ER} |-> cmd_wide && $past(st_r.ph_cnt) == 6'h1f
      || cmd_wide && quad_peripheral_mode;
  endproperty
  a_wide_erase: assert property (p_wide_erase) // [RL7]
    else $error("wide erase address length wrong");

  property p_legacy_len;
    @(posedge core_clk) disable iff (!rst_b)
    cmd_start && cmd_opcode inside {`SFCD_OP_READ, `SFCD_OP_FREAD,
      `SFCD_OP_PROG, `SFCD_OP_PARAM} |-> cmd_wide == addr_len_volatile_bit;
  endproperty
  a_legacy_len: assert property (p_legacy_len) // [RL8]
    else $error("legacy address length ignores mode bit");

  property p_wide_on;
    @(posedge core_clk) disable iff (!rst_b)
    cmd_done && cmd_opcode == `SFCD_OP_WIDE_ON |-> addr_len_volatile_bit
      ##1 !cmd_done;
  endproperty
  a_wide_on: assert property (p_wide_on) // [RL13]
    else $error("wide address mode not entered");

  property p_soft_reset;
    @(posedge core_clk) disable iff (!rst_b)
    soft_reset && !cmd_done ##1 !cmd_done |->
      addr_len_volatile_bit == $past(addr_len_default_bit);
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [RL5]
    else $error("address length not reloaded");

  property p_status_src;
    @(posedge core_clk) disable iff (!rst_b)
    st_r.phase == SFCD_DOUT && cmd_opcode == `SFCD_OP_STAT1 |->
      rd_src == SFCD_SRC_STAT1;
  endproperty
  a_status_src: assert property (p_status_src) // [RL9]
    else $error("status one read wrong source");

  property p_skip_quiet;
    @(posedge core_clk) disable iff (!rst_b)
    st_r.phase == SFCD_SKIP |=> quad_io_lines_oe == 4'h0 && !rd_next;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) // [RL19]
    else $error("output driven on unknown opcode");

  property p_cs_clear;
    @(posedge core_clk) disable iff (!rst_b)
    cs_s |=> st_r.ph_cnt == 6'h00 && st_r.tot_bits == 3'h0 &&
      st_r.phase == SFCD_IDLE;
  endproperty
  a_cs_clear: assert property (p_cs_clear) // [RL20]
    else $error("counters not cleared with select high");

  property p_nv_wen;
    @(posedge core_clk) disable iff (!rst_b)
    cmd_done && cmd_opcode == `SFCD_OP_NV_WEN |-> nv_write_enable;
  endproperty
  a_nv_wen: assert property (p_nv_wen) // [RL12]
    else $error("non-volatile write enable not set");
endmodule // sfcd_decoder

// file: rtl/sfcd_map.svh
// Opcode values, field widths and counts for the serial flash command decoder
`ifndef SFCD_MAP_SVH
`define SFCD_MAP_SVH
// =====================================================================
// Array reads
`define SFCD_OP_READ 8'h03
`define SFCD_OP_WREAD 8'h13
`define SFCD_OP_FREAD 8'h0b
`define SFCD_OP_WFREAD 8'h0c
`define SFCD_OP_DOREAD 8'h3b
`define SFCD_OP_WDOREAD 8'h3c
`define SFCD_OP_QOREAD 8'h6b
`define SFCD_OP_WQOREAD 8'h6c
`define SFCD_OP_DIOREAD 8'hbb
`define SFCD_OP_WDIOREAD 8'hbc
`define SFCD_OP_QIOREAD 8'heb
`define SFCD_OP_WQIOREAD 8'hec
`define SFCD_OP_DDRREAD 8'hed
`define SFCD_OP_WDDRREAD 8'hee
// =====================================================================
// Program and erase
`define SFCD_OP_PROG 8'h02
`define SFCD_OP_WPROG 8'h12
`define SFCD_OP_QPROG 8'h32
`define SFCD_OP_WQPROG 8'h34
`define SFCD_OP_SECT_ER 8'h20
`define SFCD_OP_WSECT_ER 8'h21
`define SFCD_OP_HALF_ER 8'h52
`define SFCD_OP_WHALF_ER 8'h53
`define SFCD_OP_BLK_ER 8'hd8
`define SFCD_OP_WBLK_ER 8'hdc
// =====================================================================
// Identification, registers, mode and learning pattern
`define SFCD_OP_MAKER_ID 8'h9f
`define SFCD_OP_PARAM 8'h5a
`define SFCD_OP_QUAD_ID 8'haf
`define SFCD_OP_UNIQ_ID 8'h4b
`define SFCD_OP_STAT1 8'h05
`define SFCD_OP_STAT2 8'h07
`define SFCD_OP_CFG1 8'h35
`define SFCD_OP_CFG2 8'h15
`define SFCD_OP_CFG3 8'h33
`define SFCD_OP_REG_WR 8'h01
`define SFCD_OP_NV_WEN 8'h06
`define SFCD_OP_V_WEN 8'h50
`define SFCD_OP_WIDE_ON 8'hb7
`define SFCD_OP_WIDE_OFF 8'he9
`define SFCD_OP_LRN_RD 8'h41
`define SFCD_OP_LRN_NV 8'h43
`define SFCD_OP_LRN_V 8'h4a
// =====================================================================
// Block lock and pointer region, mode-sized and always-wide forms
`define SFCD_OP_LOCK_RD 8'h3d
`define SFCD_OP_LOCK_SET 8'h36
`define SFCD_OP_LOCK_CLR 8'h39
`define SFCD_OP_PTR_SET 8'hfb
`define SFCD_OP_WLOCK_RD 8'he0
`define SFCD_OP_WLOCK_SET 8'he1
`define SFCD_OP_WLOCK_CLR 8'he2
`define SFCD_OP_WPTR_SET 8'he3
// =====================================================================
// Field widths and counts
`define SFCD_BYTE_BITS 6'h08
`define SFCD_ADDR3_BITS 6'h18
`define SFCD_ADDR4_BITS 6'h20
`define SFCD_REG_WR_LAST 3'h3
`endif

// file: rtl/sfcd_pkg.sv
// Types shared by the serial flash command decoder
package sfcd_pkg;
  // ===================================================================
  // Command phases
  typedef enum logic [2:0] {
    SFCD_IDLE = 3'b000,
    SFCD_OPC  = 3'b001,
    SFCD_ADDR = 3'b010,
    SFCD_DOUT = 3'b011,
    SFCD_DIN  = 3'b100,
    SFCD_WAIT = 3'b101,
    SFCD_SKIP = 3'b110
  } sfcd_phase_t;

  typedef enum logic [1:0] {
    SFCD_AL_NONE = 2'b00,
    SFCD_AL_MODE = 2'b01,
    SFCD_AL_WIDE = 2'b10
  } sfcd_alen_t;

  // Source of the bytes streamed back to the host
  typedef enum logic [3:0] {
    SFCD_SRC_NONE = 4'b0000,
    SFCD_SRC_ARRAY = 4'b0001,
    SFCD_SRC_STAT1 = 4'b0010,
    SFCD_SRC_STAT2 = 4'b0011,
    SFCD_SRC_CFG1 = 4'b0100,
    SFCD_SRC_CFG2 = 4'b0101,
    SFCD_SRC_CFG3 = 4'b0110,
    SFCD_SRC_PARAM = 4'b0111,
    SFCD_SRC_MAKER = 4'b1000,
    SFCD_SRC_QUAD_ID = 4'b1001,
    SFCD_SRC_UNIQ_ID = 4'b1010,
    SFCD_SRC_LEARN = 4'b1011,
    SFCD_SRC_LOCK = 4'b1100
  } sfcd_src_t;

  typedef struct packed {
    logic known;
    logic qpi_ok;
    sfcd_alen_t alen;
    logic dout;
    logic din;
    sfcd_src_t src;
  } sfcd_cmd_t;

  // ===================================================================
  // Decoder state, registered as one word
  typedef struct packed {
    sfcd_phase_t phase;
    logic [2:0] tot_bits;
    logic [5:0] ph_cnt;
    logic [7:0] in_sr;
    logic [7:0] opc;
    sfcd_cmd_t cmd;
    logic [31:0] addr;
    logic wide;
    logic addr_len;
    logic loaded;
    logic nv_wel;
    logic v_wel;
    logic sclk_d;
    logic [7:0] out_sr;
    logic [3:0] out_cnt;
    logic [2:0] wr_idx;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic cmd_start;
    logic cmd_done;
    logic cmd_discard;
    logic rd_next;
    logic wr_strobe;
    logic [7:0] wr_data;
  } sfcd_state_t;

  function automatic sfcd_cmd_t sfcd_mk(input logic q,
      input sfcd_alen_t al, input logic dout, input logic din,
      input sfcd_src_t src);
    sfcd_cmd_t c;
    c.known = 1'b1;
    c.qpi_ok = q;
    c.alen = al;
    c.dout = dout;
    c.din = din;
    c.src = src;
    return c;
  endfunction
endpackage

// file: rtl/sfcd_sync.sv
// Two-stage synchroniser for the host pins
module sfcd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ===================================================================
  // First stage feeds the second stage only
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sfcd_sync

// file: verification/serial_flash_command_decoder_bench.sv
// Self-checking bench for the serial flash command decoder
module serial_flash_command_decoder_bench
  import sfcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
  typedef struct packed {
    logic [7:0] opc;
    logic full;
    logic [31:0] addr;
    logic wide;
    logic chk_src;
    sfcd_src_t src;
  } sfcdb_exp_t;
  sfcdb_exp_t exq[$];
  sfcdb_exp_t e;
  logic [10:0] wrq[$];
  logic [10:0] w_e;
  logic disc_p, rnext, qpm = 0;
  int rdn = 0;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic core_clk = 0, rst_b = 0, def_bit = 1, soft_rst = 0, we_clr = 0;
  logic [7:0] rd_data = 8'h00, rd, opc, wdat;
  logic cs_b, sclk, disc, oe_any, alv, nvwe, vwe, start, done, wide, wstb;
  logic [3:0] hio, io_in, io_out, io_oe;
  logic [31:0] addr;
  logic [2:0] widx;
  sfcd_src_t src;
  assign io_in = (io_out & io_oe) | (hio & ~io_oe);
  initial forever #2 core_clk = ~core_clk;
  sfcd_host host (.core_clk(core_clk), .cs_b(cs_b), .sclk(sclk), .io(hio),
    .io_out(io_out), .io_oe(io_oe));
  // Quad mode carries only commands that it supports
  sfcd_decoder DUT (.core_clk(core_clk), .rst_b(rst_b), .cs_b_pin(cs_b),
    .sclk_pin(sclk), .quad_io_lines_in(io_in),
    .addr_len_default_bit(def_bit), .soft_reset(soft_rst),
    .quad_peripheral_mode(qpm), .write_enable_clear(we_clr),
    .rd_data(rd_data), .quad_io_lines_out(io_out), .quad_io_lines_oe(io_oe),
    .addr_len_volatile_bit(alv), .nv_write_enable(nvwe),
    .volatile_write_enable(vwe), .cmd_opcode(opc), .cmd_addr(addr),
    .cmd_wide(wide), .rd_src(src), .cmd_start(start), .cmd_done(done),
    .cmd_discard(disc_p), .rd_next(rnext), .wr_strobe(wstb), .wr_index(widx),
    .wr_data(wdat));
  task automatic close_out();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ===================================================================
  // Output watcher
  always @(negedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
    if (disc_p === 1'b1) disc = 1'b1;
    if (io_oe !== 4'h0) oe_any = 1'b1;
    if (rnext === 1'b1) rdn++;
    if (done === 1'b1) `CHK(opc, e.opc)
    if (wstb === 1'b1) begin
      w_e = wrq.pop_front();
      `CHK({widx, wdat}, w_e)
    end
    if (start === 1'b1) begin
      e = exq.pop_front();
      `CHK(opc, e.opc)
      if (e.full) `CHK(addr, e.addr)
      if (e.full) `CHK(wide, e.wide)
      if (e.chk_src) `CHK(src, e.src)
    end
  end
  task automatic expect_cmd(input logic [7:0] o, input logic f,
      input logic [31:0] a, input logic w, input logic c, input sfcd_src_t s);
    exq.push_back({o, f, a, w, c, s});
  endtask
  task automatic simple(input logic [7:0] o);
    expect_cmd(o, 1'b0, 32'h0, 1'b0, 1'b0, SFCD_SRC_NONE);
    host.frame({o, 56'h0}, 8, 0, rd);
  endtask
  // ===================================================================
  // Main sequence
  initial begin
    logic [7:0] aop[12] = '{8'h13, 8'h0c, 8'hbc, 8'h53, 8'hdc, 8'h03, 8'h0b,
      8'h02, 8'h5a, 8'h3d, 8'h36, 8'hfb};
    logic [7:0] rop[9] = '{8'h05, 8'h07, 8'h35, 8'h15, 8'h33, 8'h9f, 8'haf,
      8'h4b, 8'h41};
    sfcd_src_t rsrc[9] = '{SFCD_SRC_STAT1, SFCD_SRC_STAT2, SFCD_SRC_CFG1,
      SFCD_SRC_CFG2, SFCD_SRC_CFG3, SFCD_SRC_MAKER, SFCD_SRC_QUAD_ID,
      SFCD_SRC_UNIQ_ID, SFCD_SRC_LEARN};
    logic [31:0] a;
    logic w;
    void'($urandom(32'h88ac9265));
    repeat (4) @(posedge core_clk);
    #1 rst_b = 1'b1;
    host.wait_n(4);
    `CHK(alv, 1'b1)
    for (int i = 1; i >= 0; i--) begin
      def_bit = i[0];
      soft_rst = 1'b1;
      host.wait_n(1);
      soft_rst = 1'b0;
      host.wait_n(2);
      `CHK(alv, i[0])
    end
    simple(8'h06);
    `CHK({nvwe, vwe}, 2'b10)
    simple(8'h50);
    `CHK({nvwe, vwe}, 2'b11)
    we_clr = 1'b1;
    host.wait_n(1);
    we_clr = 1'b0;
    host.wait_n(2);
    `CHK({nvwe, vwe}, 2'b00)
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        disc = 1'b0;
        host.frame({8'hb7, 56'h0}, 7, 0, rd);
        `CHK({disc, alv}, 2'b10)
        simple(8'hb7);
        `CHK(alv, 1'b1)
      end
      for (int i = 0; i < 12; i++) begin
        a = $urandom();
        w = (i < 5) || m;
        if (!w) a[31:24] = 8'h00;
        expect_cmd(aop[i], 1'b1, a, w, 1'b0, SFCD_SRC_NONE);
        host.frame(w ? {aop[i], a, 24'h0} : {aop[i], a[23:0], 32'h0},
          w ? 40 : 32, 0, rd);
      end
    end
    simple(8'he9);
    `CHK(alv, 1'b0)
    qpm = 1'b1;
    rd_data = $urandom();
    expect_cmd(8'h05, 1'b0, 32'h0, 1'b0, 1'b1, SFCD_SRC_STAT1);
    host.frame({8'h05, 56'h0}, 2, 2, rd, 1'b1);
    `CHK(rd, rd_data)
    expect_cmd(8'hb7, 1'b0, 32'h0, 1'b0, 1'b0, SFCD_SRC_NONE);
    host.frame({8'hb7, 56'h0}, 2, 0, rd, 1'b1);
    `CHK(alv, 1'b1)
    qpm = 1'b0;
    rdn = 0;
    for (int i = 0; i < 9; i++) begin
      rd_data = $urandom();
      expect_cmd(rop[i], 1'b0, 32'h0, 1'b0, 1'b1, rsrc[i]);
      host.frame({rop[i], 56'h0}, 8, 8, rd);
      `CHK(rd, rd_data)
    end
    `CHK(rdn, 18)
    a = $urandom();
    for (int i = 0; i < 4; i++)
      wrq.push_back({i[2:0] + 3'h1, a[31-8*i -: 8]});
    expect_cmd(8'h01, 1'b0, 32'h0, 1'b0, 1'b0, SFCD_SRC_NONE);
    host.frame({8'h01, a, 24'h0}, 40, 0, rd);
    for (int i = 0; i < 2; i++) begin
      wrq.push_back({3'h1, a[7:0]});
      expect_cmd(i ? 8'h4a : 8'h43, 1'b0, 32'h0, 1'b0, 1'b0, SFCD_SRC_NONE);
      host.frame({i ? 8'h4a : 8'h43, a[7:0], 48'h0}, 16, 0, rd);
    end
    oe_any = 1'b0;
    rdn = 0;
    host.frame({8'h00, 56'h0}, 8, 8, rd);
    `CHK(oe_any, 1'b0)
    `CHK(rdn, 0)
    `CHK(exq.size() + wrq.size(), 0)
    close_out();
  end
endmodule // serial_flash_command_decoder_bench

// file: verification/sfcd_host.sv
// Host controller model driving select, clock and serial input
module sfcd_host (
  input wire logic core_clk,
  output logic cs_b,
  output logic sclk,
  output logic [3:0] io,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic miso;
  // Released output line shows a toggling pattern, never the last bit
  assign miso = io_oe[1] ? io_out[1] : sclk;
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    io = 4'h0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Clock stands low outside frames; 8 core clocks per half period
  task automatic frame(input logic [63:0] bits, input int n, input int nrd,
      output logic [7:0] rd, input logic q = 1'b0);
    rd = 8'h00;
    wait_n(1);
    cs_b = 1'b0;
    for (int i = 0; i < n + nrd; i++) begin
      if (q) io = (i < n) ? bits[63-4*i -: 4] : ~io;
      else begin
        io[0] = (i < n) ? bits[63-i] : ~io[0];
        io[3:1] = ~io[3:1];
      end
      wait_n(8);
      sclk = 1'b1;
      if (i >= n) rd = q ? {rd[3:0], io_out} : {rd[6:0], miso};
      wait_n(8);
      sclk = 1'b0;
    end
    wait_n(8);
    cs_b = 1'b1;
    wait_n(16);
  endtask
endmodule // sfcd_host
